// [inc/frc_pkg.sv]
package frc_pkg;

    typedef logic [5:0]  frc_addr_t;
    typedef logic [6:0]  frc_count_t;
    typedef logic [12:0] frc_txcnt_t;

    typedef enum {
        FRC_SEL_NONE,
        FRC_SEL_FIFO_COUNT,
        FRC_SEL_FIFO_STATUS,
        FRC_SEL_COLLISION,
        FRC_SEL_TX_HIGH,
        FRC_SEL_TX_LOW
    } frc_sel_t;

endpackage

// [inc/frc_regs.svh]
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FRC_ADDR_FIFO_COUNT   6'h1a
`define FRC_ADDR_FIFO_STATUS  6'h1b
`define FRC_ADDR_COLLISION    6'h1c
`define FRC_ADDR_TX_HIGH      6'h1d
`define FRC_ADDR_TX_LOW       6'h1e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FRC_STAT_UNF_BIT      6
`define FRC_STAT_OVR_BIT      5
`define FRC_STAT_NCP_BIT      4
`define FRC_STAT_LB_MSB       3
`define FRC_STAT_LB_LSB       1
`define FRC_STAT_NP_BIT       0
`define FRC_COL_BYTE_MSB      7
`define FRC_COL_BYTE_LSB      4
`define FRC_COL_BIT_MSB       3
`define FRC_COL_BIT_LSB       1
`define FRC_COL_PAR_BIT       0
`define FRC_TXL_CNT_MSB       7
`define FRC_TXL_CNT_LSB       3
`define FRC_TXL_SPLIT_MSB     2
`define FRC_TXL_SPLIT_LSB     0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define FRC_RESET_BYTE        8'h00
`define FRC_FIFO_DEPTH        7'h60

`endif

// [rtl/frc_fifo_track.sv]
`timescale 1ns/1ps
`include "frc_regs.svh"

module frc_fifo_track
    import frc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       soft_clr,
    input  wire logic       push,
    input  wire logic       pop,
    output frc_count_t      count,
    output logic            ovr_evt,
    output logic            unf_evt
);

    frc_count_t count_q;
    frc_count_t count_d;

    // ----------------------------------------------------------------
    // occupancy
    // ----------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        ovr_evt = push && (count_q == `FRC_FIFO_DEPTH) && !pop;
        unf_evt = pop && (count_q == 7'h00);
        if (soft_clr) begin
            count_d = 7'h00;
        end else if (push && !pop) begin
            // a byte arriving into a full buffer is dropped
            if (count_q != `FRC_FIFO_DEPTH) begin
                count_d = count_q + 7'h01;
            end
        end else if (pop && !push) begin
            if (count_q != 7'h00) begin
                count_d = count_q - 7'h01;
            end
        end else if (push && pop && count_q == 7'h00) begin
            // pop of an empty buffer misses the byte pushed alongside
            count_d = 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q <= 7'h00;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;

endmodule

// [rtl/frc_status_regs.sv]
`timescale 1ns/1ps
`include "frc_regs.svh"


module frc_status_regs
    import frc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       set_default,
    input  wire logic       fifo_clear,
    input  wire logic       rx_push,
    input  wire logic       rx_push_partial,
    input  wire logic [2:0] rx_push_bits,
    input  wire logic       rx_push_no_parity,
    input  wire logic       host_fifo_pop,
    input  wire logic       rx_frame_start,
    input  wire logic       col_evt,
    input  wire logic       col_short_frame,
    input  wire logic [3:0] col_bytes,
    input  wire logic [2:0] col_bits,
    input  wire logic       col_on_parity,
    input  frc_addr_t       reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output frc_txcnt_t      tx_byte_count,
    output logic [2:0]      tx_split_bits,
    output frc_count_t      fifo_count,
    output logic            missing_parity_err
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic frc_sel_t decode(input frc_addr_t a);
        if (a == `FRC_ADDR_FIFO_COUNT) begin
            return FRC_SEL_FIFO_COUNT;
        end else if (a == `FRC_ADDR_FIFO_STATUS) begin
            return FRC_SEL_FIFO_STATUS;
        end else if (a == `FRC_ADDR_COLLISION) begin
            return FRC_SEL_COLLISION;
        end else if (a == `FRC_ADDR_TX_HIGH) begin
            return FRC_SEL_TX_HIGH;
        end else if (a == `FRC_ADDR_TX_LOW) begin
            return FRC_SEL_TX_LOW;
        end else begin
            return FRC_SEL_NONE;
        end
    endfunction

    frc_sel_t   sel;
    logic       clr_all;
    frc_count_t cnt;
    logic       ovr_evt;
    logic       unf_evt;

    assign sel     = decode(reg_addr);
    assign clr_all = set_default;

    frc_fifo_track u_track (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .soft_clr (set_default || fifo_clear),
        .push     (rx_push),
        .pop      (host_fifo_pop),
        .count    (cnt),
        .ovr_evt  (ovr_evt),
        .unf_evt  (unf_evt)
    );

    // ----------------------------------------------------------------
    // fifo status
    // ----------------------------------------------------------------
    logic       unf_q, unf_d;
    logic       ovr_q, ovr_d;
    logic       ncp_q, ncp_d;
    logic [2:0] last_byte_valid_bits_q, last_byte_valid_bits_d;
    logic       missing_parity_flag_q, missing_parity_flag_d;
    logic       stat_rd;

    assign stat_rd = reg_rd && (sel == FRC_SEL_FIFO_STATUS);

    always_comb begin
        unf_d                  = unf_q;
        ovr_d                  = ovr_q;
        ncp_d                  = ncp_q;
        last_byte_valid_bits_d = last_byte_valid_bits_q;
        missing_parity_flag_d  = missing_parity_flag_q;
        // read and empty clears come first so a push in the same cycle wins
        if (stat_rd) begin
            ncp_d                  = 1'b0;
            last_byte_valid_bits_d = 3'h0;
            missing_parity_flag_d  = 1'b0;
        end
        if (cnt == 7'h00) begin
            ncp_d                  = 1'b0;
            last_byte_valid_bits_d = 3'h0;
        end
        if (rx_push) begin
            ncp_d                  = rx_push_partial;
            last_byte_valid_bits_d = rx_push_partial ? rx_push_bits : 3'h0;
            missing_parity_flag_d  = rx_push_no_parity;
        end
        // an error event in the cycle of a buffer clear must not be lost
        if (fifo_clear) begin
            unf_d = 1'b0;
            ovr_d = 1'b0;
        end
        if (unf_evt) begin
            unf_d = 1'b1;
        end
        if (ovr_evt) begin
            ovr_d = 1'b1;
        end
        if (clr_all) begin
            unf_d                  = 1'b0;
            ovr_d                  = 1'b0;
            ncp_d                  = 1'b0;
            last_byte_valid_bits_d = 3'h0;
            missing_parity_flag_d  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unf_q                  <= 1'b0;
            ovr_q                  <= 1'b0;
            ncp_q                  <= 1'b0;
            last_byte_valid_bits_q <= 3'h0;
            missing_parity_flag_q  <= 1'b0;
        end else begin
            unf_q                  <= unf_d;
            ovr_q                  <= ovr_d;
            ncp_q                  <= ncp_d;
            last_byte_valid_bits_q <= last_byte_valid_bits_d;
            missing_parity_flag_q  <= missing_parity_flag_d;
        end
    end

    // ----------------------------------------------------------------
    // collision position
    // ----------------------------------------------------------------
    logic [7:0] col_q, col_d;
    logic       col_seen_q, col_seen_d;

    always_comb begin
        col_d      = col_q;
        col_seen_d = col_seen_q;
        if (rx_frame_start) begin
            col_seen_d = 1'b0;
        end
        // only the first collision of a short frame is kept
        if (col_evt && col_short_frame && !col_seen_q) begin
            col_d      = {col_bytes, col_bits, col_on_parity};
            col_seen_d = 1'b1;
        end else if (col_evt) begin
            col_seen_d = 1'b1;
        end
        if (clr_all) begin
            col_d      = `FRC_RESET_BYTE;
            col_seen_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            col_q      <= `FRC_RESET_BYTE;
            col_seen_q <= 1'b0;
        end else begin
            col_q      <= col_d;
            col_seen_q <= col_seen_d;
        end
    end

    // ----------------------------------------------------------------
    // transmit count
    // ----------------------------------------------------------------
    logic [7:0] txh_q, txh_d;
    logic [7:0] txl_q, txl_d;

    always_comb begin
        txh_d = txh_q;
        txl_d = txl_q;
        if (reg_wr && sel == FRC_SEL_TX_HIGH) begin
            txh_d = reg_wdata;
        end
        if (reg_wr && sel == FRC_SEL_TX_LOW) begin
            txl_d = reg_wdata;
        end
        if (clr_all) begin
            txh_d = `FRC_RESET_BYTE;
            txl_d = `FRC_RESET_BYTE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txh_q <= `FRC_RESET_BYTE;
            txl_q <= `FRC_RESET_BYTE;
        end else begin
            txh_q <= txh_d;
            txl_q <= txl_d;
        end
    end

    // thirteen bits cap the count at 8191 without a saturating check
    assign tx_byte_count = {txh_q, txl_q[`FRC_TXL_CNT_MSB:`FRC_TXL_CNT_LSB]};
    assign tx_split_bits = txl_q[`FRC_TXL_SPLIT_MSB:`FRC_TXL_SPLIT_LSB];

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (sel)
                FRC_SEL_FIFO_COUNT:  rdata_d = {1'b0, cnt};
                FRC_SEL_FIFO_STATUS: rdata_d = {1'b0, unf_q, ovr_q, ncp_q,
                                                last_byte_valid_bits_q,
                                                missing_parity_flag_q};
                FRC_SEL_COLLISION:   rdata_d = col_q;
                FRC_SEL_TX_HIGH:     rdata_d = txh_q;
                FRC_SEL_TX_LOW:      rdata_d = txl_q;
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata          = rdata_q;
    assign fifo_count         = cnt;
    assign missing_parity_err = missing_parity_flag_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_partial_push;
        rx_push && rx_push_partial && !clr_all;
    endsequence

    sequence s_status_read;
        stat_rd && !rx_push && !clr_all;
    endsequence

    a_underflow_set: assert property (
        host_fifo_pop && cnt == 7'h00 && !clr_all && !fifo_clear |=> unf_q)
        else $error("underflow flag not set");

    a_overflow_drop: assert property (
        rx_push && !host_fifo_pop && cnt == 7'h60 && !clr_all && !fifo_clear
        |=> ovr_q && cnt == 7'h60)
        else $error("overflow not flagged or byte kept");

    a_partial_kept: assert property (
        s_partial_push |=> ncp_q && last_byte_valid_bits_q == $past(rx_push_bits))
        else $error("partial byte info not captured");

    a_parity_missing: assert property (
        rx_push && rx_push_no_parity && !clr_all |=> missing_parity_err)
        else $error("missing parity not flagged");

    a_status_rd_clear: assert property (
        s_status_read ##1 1'b1 |-> !ncp_q && !missing_parity_flag_q
                                   && last_byte_valid_bits_q == 3'h0)
        else $error("status read did not clear partial bits");

    a_status_rd_data: assert property (
        s_status_read |=> reg_rdata[3:1] == $past(last_byte_valid_bits_q)
                          && reg_rdata[4] == $past(ncp_q))
        else $error("status read data wrong");

    a_empty_clears: assert property (
        cnt == 7'h00 && !rx_push |=> !ncp_q && last_byte_valid_bits_q == 3'h0)
        else $error("empty buffer left partial info");

    a_empty_count_rd: assert property (
        reg_rd && sel == FRC_SEL_FIFO_COUNT && cnt == 7'h00 |=> reg_rdata == 8'h00)
        else $error("empty count not zero");

    a_count_range: assert property (
        cnt <= 7'h60)
        else $error("count beyond capacity");

    a_col_record: assert property (
        col_evt && col_short_frame && !col_seen_q && !clr_all
        |=> col_q == {$past(col_bytes), $past(col_bits), $past(col_on_parity)})
        else $error("collision position not recorded");

    a_col_long_held: assert property (
        col_evt && !col_short_frame && !clr_all |=> $stable(col_q))
        else $error("long frame collision recorded");

    a_tx_high_wr: assert property (
        reg_wr && sel == FRC_SEL_TX_HIGH && !clr_all
        |=> tx_byte_count[12:5] == $past(reg_wdata))
        else $error("transmit count high bits wrong");

    a_tx_low_wr: assert property (
        reg_wr && sel == FRC_SEL_TX_LOW && !clr_all
        |=> tx_byte_count[4:0] == $past(reg_wdata[7:3])
            && tx_split_bits == $past(reg_wdata[2:0]))
        else $error("transmit count low bits wrong");

    a_default_zero: assert property (
        set_default |=> col_q == 8'h00 && tx_byte_count == 13'h0000
                        && !unf_q && !ovr_q && !ncp_q && cnt == 7'h00)
        else $error("set default left state");

endmodule

// [tb/tb_fifo_collision_txcount_regs.sv]
`timescale 1ns/1ps
`include "frc_regs.svh"

module tb_fifo_collision_txcount_regs
    import frc_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       set_default = 1'b0;
    logic       fifo_clear = 1'b0;
    logic       rx_push = 1'b0;
    logic       rx_push_partial = 1'b0;
    logic [2:0] rx_push_bits = 3'h0;
    logic       rx_push_no_parity = 1'b0;
    logic       host_fifo_pop = 1'b0;
    logic       rx_frame_start = 1'b0;
    logic       col_evt = 1'b0;
    logic       col_short_frame = 1'b0;
    logic [3:0] col_bytes = 4'h0;
    logic [2:0] col_bits = 3'h0;
    logic       col_on_parity = 1'b0;
    frc_addr_t  reg_addr = 6'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    frc_txcnt_t tx_byte_count;
    logic [2:0] tx_split_bits;
    frc_count_t fifo_count;
    logic       missing_parity_err;
    int         err_total = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #50 sys_clk = ~sys_clk;

    frc_status_regs DUT (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .set_default        (set_default),
        .fifo_clear         (fifo_clear),
        .rx_push            (rx_push),
        .rx_push_partial    (rx_push_partial),
        .rx_push_bits       (rx_push_bits),
        .rx_push_no_parity  (rx_push_no_parity),
        .host_fifo_pop      (host_fifo_pop),
        .rx_frame_start     (rx_frame_start),
        .col_evt            (col_evt),
        .col_short_frame    (col_short_frame),
        .col_bytes          (col_bytes),
        .col_bits           (col_bits),
        .col_on_parity      (col_on_parity),
        .reg_addr           (reg_addr),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .tx_byte_count      (tx_byte_count),
        .tx_split_bits      (tx_split_bits),
        .fifo_count         (fifo_count),
        .missing_parity_err (missing_parity_err)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bounded run: a few hundred cycles are needed, so a hang shows quickly
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            final_report();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // read data is looked at one cycle after the strobe, where it stands
    task automatic rd_chk(input frc_addr_t a, input logic [7:0] exp, input string msg);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(exp), msg);
    endtask

    task automatic wr(input frc_addr_t a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic push(input logic p, input logic [2:0] b, input logic np, input int n);
        @(posedge sys_clk);
        rx_push           <= 1'b1;
        rx_push_partial   <= p;
        rx_push_bits      <= b;
        rx_push_no_parity <= np;
        repeat (n) @(posedge sys_clk);
        rx_push           <= 1'b0;
        rx_push_partial   <= 1'b0;
        rx_push_no_parity <= 1'b0;
        #1;
    endtask

    // 0 pop, 1 fifo clear, 2 set default, 3 frame start
    task automatic strobe(input int which);
        @(posedge sys_clk);
        case (which)
            0: host_fifo_pop <= 1'b1;
            1: fifo_clear <= 1'b1;
            2: set_default <= 1'b1;
            default: rx_frame_start <= 1'b1;
        endcase
        @(posedge sys_clk);
        host_fifo_pop  <= 1'b0;
        fifo_clear     <= 1'b0;
        set_default    <= 1'b0;
        rx_frame_start <= 1'b0;
        #1;
    endtask

    task automatic col(input logic s, input logic [3:0] by, input logic [2:0] bi, input logic p);
        @(posedge sys_clk);
        col_evt         <= 1'b1;
        col_short_frame <= s;
        col_bytes       <= by;
        col_bits        <= bi;
        col_on_parity   <= p;
        @(posedge sys_clk);
        col_evt         <= 1'b0;
    endtask

    task automatic all_zero(input string msg);
        for (int a = 'h1a; a <= 'h1e; a++) begin
            rd_chk(6'(a), 8'h00, msg);
        end
        check(16'(tx_byte_count), 16'h0000, msg);
        check(16'(fifo_count), 16'h0000, msg);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_partial();
        push(1'b1, 3'h5, 1'b1, 1);
        check(16'(fifo_count), 16'h0001, "count after push");
        check(16'(missing_parity_err), 16'h0001, "parity flag");
        // host flow: both status registers first, the second one clears on read, then data
        rd_chk(`FRC_ADDR_FIFO_COUNT, 8'h01, "count before data read");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h1b, "partial status");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h00, "status after read");
        check(16'(missing_parity_err), 16'h0000, "parity flag cleared");
        strobe(0);
        // partial byte lands in empty buffer, then drains: count info goes, parity stays
        push(1'b1, 3'h3, 1'b1, 1);
        strobe(0);
        rd_chk(`FRC_ADDR_FIFO_COUNT, 8'h00, "count empty");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h01, "empty clears partial");
    endtask

    task automatic t_underflow();
        strobe(0);
        check(16'(fifo_count), 16'h0000, "count stays at zero");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h40, "underflow");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h40, "underflow sticky");
        strobe(1);
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h00, "underflow cleared");
    endtask

    task automatic t_overflow();
        push(1'b0, 3'h0, 1'b0, 96);
        check(16'(fifo_count), 16'h0060, "full count");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h00, "no overflow at 96");
        push(1'b0, 3'h0, 1'b0, 1);
        check(16'(fifo_count), 16'h0060, "excess discarded");
        rd_chk(`FRC_ADDR_FIFO_COUNT, 8'h60, "count register");
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h20, "overflow");
        strobe(0);
        check(16'(fifo_count), 16'h005f, "count after pop");
        strobe(1);
        check(16'(fifo_count), 16'h0000, "count cleared");
    endtask

    task automatic t_collision();
        strobe(3);
        col(1'b1, 4'h3, 3'h5, 1'b1);
        col(1'b1, 4'h9, 3'h2, 1'b0);
        rd_chk(`FRC_ADDR_COLLISION, 8'h3b, "first collision kept");
        strobe(3);
        col(1'b0, 4'h7, 3'h1, 1'b0);
        rd_chk(`FRC_ADDR_COLLISION, 8'h3b, "long frame ignored");
        strobe(3);
        col(1'b1, 4'hf, 3'h7, 1'b0);
        rd_chk(`FRC_ADDR_COLLISION, 8'hfe, "byte and bit position");
        wr(`FRC_ADDR_COLLISION, 8'h00);
        rd_chk(`FRC_ADDR_COLLISION, 8'hfe, "read-only position");
    endtask

    task automatic t_txcount();
        wr(`FRC_ADDR_TX_HIGH, 8'hff);
        wr(`FRC_ADDR_TX_LOW, 8'hfb);
        #1;
        check(16'(tx_byte_count), 16'h1fff, "max count");
        check(16'(tx_split_bits), 16'h0003, "split bits");
        rd_chk(`FRC_ADDR_TX_HIGH, 8'hff, "high readback");
        wr(`FRC_ADDR_TX_HIGH, 8'ha5);
        wr(`FRC_ADDR_TX_LOW, 8'h50);
        #1;
        check(16'(tx_byte_count), 16'h14aa, "count bits 12:5 and 4:0");
        check(16'(tx_split_bits), 16'h0000, "no split byte");
        rd_chk(`FRC_ADDR_TX_LOW, 8'h50, "low readback");
        wr(`FRC_ADDR_FIFO_STATUS, 8'hff);
        rd_chk(`FRC_ADDR_FIFO_STATUS, 8'h00, "status not writable");
        rd_chk(6'h3f, 8'h00, "unmapped address");
    endtask

    task automatic t_default();
        push(1'b1, 3'h6, 1'b1, 2);
        strobe(3);
        col(1'b1, 4'h1, 3'h4, 1'b0);
        strobe(0);
        strobe(0);
        strobe(0);
        strobe(2);
        check(16'(missing_parity_err), 16'h0000, "parity after default");
        all_zero("after set default");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        all_zero("after reset");
        t_partial();
        t_underflow();
        t_overflow();
        t_collision();
        t_txcount();
        t_default();
        final_report();
    end
endmodule
